// *** include/sece_pkg.sv ***
// Constants, command decode and state layouts for the serial EEPROM command engine.
// Assumes a 100 MHz system clock and a serial clock supplied by an external master.
// ==================================================================
// Package
package sece_pkg;
    // ==================================================================
    // Sizes
    localparam int          BYTE_W     = 8;
    localparam int          ADDR_W     = 7;
    localparam int          MEM_DEPTH  = 128;
    localparam int          PAGE_BYTES = 8;
    localparam int          TIMER_W    = 20;
    localparam int          BYTECNT_W  = 5;
    // ==================================================================
    // Operation codes: upper nibble zero, bit 3 ignored, low three bits select
    localparam logic [3:0]  OPC_HI      = 4'h0;
    localparam logic [2:0]  OPC_SET     = 3'h6;
    localparam logic [2:0]  OPC_CLEAR   = 3'h4;
    localparam logic [2:0]  OPC_SREAD   = 3'h5;
    localparam logic [2:0]  OPC_SWRITE  = 3'h1;
    localparam logic [2:0]  OPC_AREAD   = 3'h3;
    localparam logic [2:0]  OPC_AWRITE  = 3'h2;
    // ==================================================================
    // Framing: whole bytes counted, opcode included
    localparam logic [4:0]  SWRITE_BYTES    = 5'h02;
    localparam logic [4:0]  AWRITE_MIN_BYTE = 5'h03;
    localparam logic [4:0]  BYTECNT_MAX     = 5'h1F;
    // ==================================================================
    // Status layout and reset values
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_WEL_BIT  = 1;
    localparam int          ST_BP_LSB   = 2;
    localparam logic [1:0]  BP_RESET    = 2'h0;
    localparam logic        WEL_RESET   = 1'b0;
    // ==================================================================
    // Protected region lower bounds per level
    localparam logic [6:0]  PROT_L1_BASE = 7'h60;
    localparam logic [6:0]  PROT_L2_BASE = 7'h40;
    localparam logic [6:0]  PROT_L3_BASE = 7'h00;
    // ==================================================================
    // Timing
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          WRITE_CYCLE_MS     = 5;
    localparam int          WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_LATCH_SET,
        CMD_LATCH_CLEAR,
        CMD_STATUS_READ,
        CMD_STATUS_WRITE,
        CMD_ARRAY_READ,
        CMD_ARRAY_WRITE
    } sece_cmd_e;

    typedef struct packed {
        logic [2:0]  nbits;
        logic [4:0]  nbytes;
        logic [6:0]  sh;
        logic [7:0]  opcode;
        logic [6:0]  addr;
        logic [7:0]  sdata;
        logic [63:0] page;
        logic [7:0]  mask;
        logic [7:0]  tx;
        logic        txon;
        logic [3:0]  stat_s1;
        logic [3:0]  stat_s2;
        logic        tog;
    } sece_link_s;

    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_prev;
        logic        wp_s1;
        logic        wp_s2;
        logic        wel;
        logic [1:0]  bp;
        logic        busy;
        logic        wr_status;
        logic [1:0]  pend_bp;
        logic [3:0]  page_idx;
        logic [63:0] page;
        logic [7:0]  mask;
        logic [19:0] timer;
        logic        frame_seen;
    } sece_sys_s;
    // ==================================================================
    // Functions
    function automatic sece_cmd_e sece_decode(input logic [7:0] b);
        sece_cmd_e k;
        k = CMD_NONE;
        if (b[7:4] == OPC_HI) begin
            case (b[2:0])
                OPC_SET:    k = CMD_LATCH_SET;
                OPC_CLEAR:  k = CMD_LATCH_CLEAR;
                OPC_SREAD:  k = CMD_STATUS_READ;
                OPC_SWRITE: k = CMD_STATUS_WRITE;
                OPC_AREAD:  k = CMD_ARRAY_READ;
                OPC_AWRITE: k = CMD_ARRAY_WRITE;
                default:    k = CMD_NONE;
            endcase
        end
        return k;
    endfunction

    function automatic logic sece_protected(input logic [1:0] bp, input logic [6:0] a);
        logic p;
        p = 1'b0;
        case (bp)
            2'h1:    p = (a >= PROT_L1_BASE);
            2'h2:    p = (a >= PROT_L2_BASE);
            2'h3:    p = (a >= PROT_L3_BASE);
            default: p = 1'b0;
        endcase
        return p;
    endfunction
endpackage

// *** hw/sece_top.sv ***
// Serial EEPROM command engine: serial slave, decode, protection, array, write timer.
// Assumes the master keeps serial_clock still while cs_n is high, and that the
// system clock runs well faster than the serial clock.
//
// Overview of operation
// - Chip select low starts a frame; input sampled on each rising serial clock.
// - Opcode is 8 bits; all fields shift most significant bit first.
// - Returned data changes on each falling serial clock edge.
// - Chip select high ends the frame; idle unless a write cycle runs.
// - Decode latch set, latch clear and status read codes, bit 3 ignored.
// - Decode status write with one byte, array read and write with address.
// - Latch clears at reset, latch clear, status write and array write completion.
// - Only the latch set command sets the write enable latch.
// - While busy only the status read command has any effect.
// - Status read repeats the status byte while clocking continues.
// - Unknown opcode keeps output disabled and does nothing at frame end.
// - Badly framed writes are abandoned at frame end.
// - Status write stores only the block protect bits.
// - Status write needs latch set and protect pin high.
// - Status value updates only at write cycle completion; busy rises meanwhile.
// - Array read streams successive bytes, wrapping from top to bottom.
// - Array read stops whenever chip select rises.
// - Array write stays in one 8 byte page, wrapping to its start.
// - Page keeps only the last 8 bytes received.
// - Protected block is never modified.
// - Other locations change only with latch set and protect pin high.
// - Status bit 0 busy, bit 1 latch, bits 2 to 3 protect level.
// - Protect levels cover none, 60h up, 40h up, all; default zero.
// - Protect pin low clears the write enable latch.
// - Status bits 4 to 7 read zero and are not kept.
`timescale 1ns/1ps
`default_nettype none

module sece_top #(
    parameter int unsigned WRITE_CYCLES = sece_pkg::WRITE_CYCLE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       serial_clock,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe,
    output logic            busy_flag,
    output logic            write_latch,
    output logic [1:0]      block_protect
);
    // ==================================================================
    // Elaboration checks
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > (2 ** sece_pkg::TIMER_W) - 1) begin : g_chk
        $error("WRITE_CYCLES out of range for the timer");
    end

    localparam logic [sece_pkg::TIMER_W-1:0] WC_LOAD = WRITE_CYCLES[sece_pkg::TIMER_W-1:0];

    // ==================================================================
    // State
    sece_pkg::sece_link_s  lk;
    sece_pkg::sece_link_s  next_lk;
    sece_pkg::sece_link_s  lk_base;
    logic                  frame_fresh;
    logic                  frame_end;
    sece_pkg::sece_sys_s   sy;
    sece_pkg::sece_sys_s   next_sy;
    logic [7:0]            mem [sece_pkg::MEM_DEPTH];
    logic                  so_q;
    logic                  so_oe_q;
    logic                  link_rst_n;
    logic [7:0]            stat_byte;
    logic [7:0]            rx;
    logic [6:0]            rd;
    sece_pkg::sece_cmd_e   cmd;
    logic                  done;

    // Deselect drops the output and marks a frame start; frame fields are kept
    // Frame fields must outlive cs_n high so the system side can still read them
    assign link_rst_n = arst_n & ~cs_n;

    // ==================================================================
    // Serial side, rising edge
    always_comb begin
        lk_base         = frame_fresh ? '0 : lk;
        lk_base.stat_s1 = lk.stat_s1;
        lk_base.stat_s2 = lk.stat_s2;
        lk_base.tog     = lk.tog;
        next_lk         = lk_base;
        next_lk.tog     = lk.tog ^ frame_fresh;
        rd              = lk_base.addr;
        rx              = {lk_base.sh, si};
        stat_byte       = {4'h0, lk.stat_s2[3:2], lk.stat_s2[1], lk.stat_s2[0]};
        next_lk.stat_s1 = {sy.bp, sy.wel, sy.busy};
        next_lk.stat_s2 = lk.stat_s1;
        next_lk.sh      = {lk_base.sh[5:0], si};
        next_lk.nbits   = lk_base.nbits + 3'h1;
        next_lk.tx      = {lk_base.tx[6:0], 1'b0};
        if (lk_base.nbits == 3'h7) begin
            if (lk_base.nbytes != sece_pkg::BYTECNT_MAX) begin
                next_lk.nbytes = lk_base.nbytes + 5'h01;
            end
            if (lk_base.nbytes == 5'h00) begin
                next_lk.opcode = rx;
                if (sece_pkg::sece_decode(rx) == sece_pkg::CMD_STATUS_READ) begin
                    next_lk.tx   = stat_byte;
                    next_lk.txon = 1'b1;
                end
            end else begin
                case (sece_pkg::sece_decode(lk_base.opcode))
                    sece_pkg::CMD_STATUS_READ: begin
                        next_lk.tx = stat_byte;
                    end
                    sece_pkg::CMD_ARRAY_READ: begin
                        if (lk_base.nbytes == 5'h01) begin
                            rd = rx[6:0];
                        end
                        next_lk.tx   = mem[rd];
                        next_lk.addr = rd + 7'h01;
                        next_lk.txon = ~lk.stat_s2[0];
                    end
                    sece_pkg::CMD_ARRAY_WRITE: begin
                        if (lk_base.nbytes == 5'h01) begin
                            next_lk.addr = rx[6:0];
                        end else begin
                            next_lk.page[lk_base.addr[2:0]*8 +: 8] = rx;
                            next_lk.mask[lk_base.addr[2:0]]        = 1'b1;
                            next_lk.addr = {lk_base.addr[6:3], lk_base.addr[2:0] + 3'h1};
                        end
                    end
                    sece_pkg::CMD_STATUS_WRITE: begin
                        if (lk_base.nbytes == 5'h01) begin
                            next_lk.sdata = rx;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge serial_clock or negedge arst_n) begin
        if (!arst_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // First rising edge after select starts the frame from cleared fields
    always_ff @(posedge serial_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_fresh <= 1'b1;
        end else begin
            frame_fresh <= 1'b0;
        end
    end

    // ==================================================================
    // Serial side, falling edge output
    always_ff @(negedge serial_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_q    <= lk.tx[7];
            so_oe_q <= lk.txon;
        end
    end

    assign so    = so_q;
    assign so_oe = so_oe_q;

    // ==================================================================
    // System side
    // Frame registers are read only after cs_n has crossed; they are still then
    always_comb begin
        next_sy         = sy;
        cmd             = sece_pkg::CMD_NONE;
        done            = 1'b0;
        // Toggle check stops a clockless select from replaying the last command
        frame_end       = sy.cs_s2 && !sy.cs_prev && (lk.tog != sy.frame_seen);
        next_sy.cs_s1   = cs_n;
        next_sy.cs_s2   = sy.cs_s1;
        next_sy.cs_prev = sy.cs_s2;
        next_sy.wp_s1   = wp_n;
        next_sy.wp_s2   = sy.wp_s1;
        if (lk.nbytes != 5'h00) begin
            cmd = sece_pkg::sece_decode(lk.opcode);
        end
        if (frame_end) begin
            next_sy.frame_seen = lk.tog;
        end
        if (sy.busy) begin
            next_sy.timer = sy.timer - 20'h00001;
            if (sy.timer == 20'h00001) begin
                done          = 1'b1;
                next_sy.busy  = 1'b0;
                next_sy.wel   = 1'b0;
                if (sy.wr_status) begin
                    next_sy.bp = sy.pend_bp;
                end
            end
        end else if (frame_end) begin
            case (cmd)
                sece_pkg::CMD_LATCH_SET: begin
                    next_sy.wel = 1'b1;
                end
                sece_pkg::CMD_LATCH_CLEAR: begin
                    next_sy.wel = 1'b0;
                end
                sece_pkg::CMD_STATUS_WRITE: begin
                    if (lk.nbytes == sece_pkg::SWRITE_BYTES && lk.nbits == 3'h0
                        && sy.wel && sy.wp_s2) begin
                        next_sy.busy      = 1'b1;
                        next_sy.timer     = WC_LOAD;
                        next_sy.wr_status = 1'b1;
                        next_sy.pend_bp   = lk.sdata[3:2];
                    end
                end
                sece_pkg::CMD_ARRAY_WRITE: begin
                    if (lk.nbytes >= sece_pkg::AWRITE_MIN_BYTE && lk.nbits == 3'h0
                        && sy.wel && sy.wp_s2) begin
                        next_sy.busy      = 1'b1;
                        next_sy.timer     = WC_LOAD;
                        next_sy.wr_status = 1'b0;
                        next_sy.page_idx  = lk.addr[6:3];
                        next_sy.page      = lk.page;
                        next_sy.mask      = lk.mask;
                    end
                end
                default: begin
                end
            endcase
        end
        if (!sy.wp_s2) begin
            next_sy.wel = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sy       <= '0;
            sy.cs_s1 <= 1'b1;
            sy.cs_s2 <= 1'b1;
            sy.cs_prev <= 1'b1;
            sy.wp_s1 <= 1'b1;
            sy.wp_s2 <= 1'b1;
            sy.wel   <= sece_pkg::WEL_RESET;
            sy.bp    <= sece_pkg::BP_RESET;
        end else begin
            sy <= next_sy;
        end
    end

    // ==================================================================
    // Array: committed page at cycle end, protected bytes skipped
    always_ff @(posedge clk) begin
        if (done && !sy.wr_status) begin
            for (int i = 0; i < sece_pkg::PAGE_BYTES; i++) begin
                if (sy.mask[i] && !sece_pkg::sece_protected(sy.bp, {sy.page_idx, 3'(i)})) begin
                    mem[{sy.page_idx, 3'(i)}] <= sy.page[i*8 +: 8];
                end
            end
        end
    end

    // ==================================================================
    // Status outputs
    assign busy_flag     = sy.busy;
    assign write_latch   = sy.wel;
    assign block_protect = sy.bp;

endmodule

`default_nettype wire

// *** sim/sece_top_asserts.sv ***
// Checker for the serial EEPROM command engine, bound to its top.
// Sees only the top ports; WRITE_CYCLES follows the bound instance.
`timescale 1ns/1ps
`default_nettype none
module sece_top_asserts #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       serial_clock,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic       wp_n,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic       busy_flag,
    input wire logic       write_latch,
    input wire logic [1:0] block_protect
);
    // ====================
    // Busy length counter
    logic [19:0] busy_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 20'h0;
        end else begin
            busy_cnt <= busy_flag ? busy_cnt + 20'h1 : 20'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ====================
    // Properties
    AST_SO_QUIET: assert property (cs_n && $past(cs_n) |-> !so_oe)
        else $error("so_oe high while deselected");
    AST_WP_CLEAR: assert property (!wp_n [*4] |-> !write_latch)
        else $error("latch kept with protect pin low");
    AST_WEL_RISE: assert property ($rose(write_latch) |-> cs_n && !busy_flag && wp_n)
        else $error("latch set at wrong moment");
    AST_BUSY_START: assert property ($rose(busy_flag) |-> cs_n && $past(write_latch))
        else $error("write cycle without latch");
    AST_BUSY_LEN: assert property ($fell(busy_flag) |-> busy_cnt >= WRITE_CYCLES
        && busy_cnt <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    AST_WEL_DROP: assert property ($fell(busy_flag) |-> ##[0:1] !write_latch)
        else $error("latch not cleared after write");
    AST_BP_FROZEN: assert property (busy_flag && $past(busy_flag) |-> $stable(block_protect))
        else $error("protect level moved during cycle");
    AST_BP_AT_END: assert property ($changed(block_protect) |-> !busy_flag
        && ($past(busy_flag) || $past(busy_flag, 2)))
        else $error("protect level changed outside cycle end");
    COV_BUSY: cover property ($rose(busy_flag));
    COV_WEL: cover property ($rose(write_latch));
    COV_OUT: cover property ($rose(so_oe));
endmodule
bind sece_top sece_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) sece_top_asserts_i (
    .clk(clk), .arst_n(arst_n), .serial_clock(serial_clock), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy_flag(busy_flag),
    .write_latch(write_latch), .block_protect(block_protect));
`default_nettype wire

// *** sim/sece_master.sv ***
// Serial master model: mode 0 frames on request from the bench.
// Clock stands still between frames; data line shows a changed level.
`timescale 1ns/1ps
`default_nettype none
module sece_master (
    output var logic serial_clock,
    output var logic cs_n,
    output var logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial begin
        serial_clock = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Sends n bits of d, gathers so at each rising edge
    task automatic xfer(input logic [127:0] d, input int n,
                        output logic [127:0] r, output logic oe);
        r = '0;
        oe = 1'b0;
        cs_n = 1'b0;
        #10;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            #7.5 serial_clock = 1'b1;
            r = {r[126:0], so};
            oe = oe | so_oe;
            #7.5 serial_clock = 1'b0;
        end
        #10 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
endmodule
`default_nettype wire

// *** sim/sece_top_tb.sv ***
// Self-checking bench for the serial EEPROM command engine.
// Serial side comes from sece_master; WC shortens the write cycle.
`timescale 1ns/1ps
`default_nettype none
module sece_top_tb;
    localparam int unsigned WC = 200;
    logic            clk = 1'b0;
    logic            arst_n = 1'b0;
    logic            wp_n = 1'b1;
    wire logic       sck, cs_n, si, so, so_oe, busy_flag, write_latch;
    wire logic [1:0] block_protect;
    logic [127:0]    rx;
    logic            oe;
    int              fails = 0;
    int              cmp_count = 0;
    always #5 clk = ~clk;
    sece_top #(.WRITE_CYCLES(WC)) sece_top_i (.clk(clk), .arst_n(arst_n), .serial_clock(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy_flag(busy_flag),
        .write_latch(write_latch), .block_protect(block_protect));
    sece_master sece_master_i (.serial_clock(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
    // ====================
    // Helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Realign to a falling edge so no sample meets a rising one
    task automatic go(input logic [127:0] d, input int n);
        sece_master_i.xfer(d, n, rx, oe);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [127:0] dat, input int nb);
        go(128'h06, 8);
        go(((128'h0200 | a) << (8 * nb)) | dat, 16 + 8 * nb);
    endtask
    task automatic rd(input logic [7:0] a, input int nb);
        go((128'h0300 | a) << (8 * nb), 16 + 8 * nb);
    endtask
    task automatic settle(input logic exp_busy);
        int k;
        check(busy_flag, exp_busy);
        for (k = 0; busy_flag !== 1'b0 && k < 400; k++) begin
            @(negedge clk);
        end
        if (k == 400) begin
            fails++;
            give_verdict();
        end
    endtask
    // ====================
    // Scenarios
    task automatic t_reset();
        check({busy_flag, write_latch, block_protect}, 4'h0);
        go(128'h050000, 24);
        check(rx[15:0], 16'h0000);
    endtask
    task automatic t_latch();
        logic [7:0] opc [4];
        opc = '{8'h06, 8'h0C, 8'h0E, 8'h04};
        for (int i = 0; i < 4; i++) begin
            go(opc[i], 8);
            check(write_latch, opc[i][1]);
        end
        go(128'h06, 8);
        go(128'h1600, 16);
        check({oe, write_latch}, 2'b01);
        go(128'h050000, 24);
        check({oe, rx[15:0]}, 17'h10202);
        go(128'h04, 8);
    endtask
    task automatic t_page();
        wr(8'h85, 80'h1122_3344_5566_7788_99AA, 10);
        go(128'h050000, 24);
        check(rx[15:0], 16'h0303);
        rd(8'h00, 1);
        check(oe, 1'b0);
        go(128'h04, 8);
        check(write_latch, 1'b1);
        settle(1'b1);
        check(write_latch, 1'b0);
        rd(8'h00, 8);
        check(rx[63:0], 64'h4455_6677_8899_AA33);
        wr(8'h7F, 8'hAB, 1);
        settle(1'b1);
        rd(8'h7F, 2);
        check(rx[15:0], 16'hAB44);
    endtask
    task automatic t_prot();
        go(128'h06, 8);
        go(128'h01FF, 16);
        check(block_protect, 2'h0);
        settle(1'b1);
        check({block_protect, write_latch}, 3'b110);
        go(128'h050000, 24);
        check(rx[15:0], 16'h0C0C);
        wr(8'h00, 8'h5A, 1);
        settle(1'b1);
        rd(8'h00, 1);
        check(rx[7:0], 8'h44);
        go(128'h06, 8);
        go(128'h0104, 16);
        settle(1'b1);
        wr(8'h7F, 8'hCD, 1);
        settle(1'b1);
        wr(8'h01, 8'hEE, 1);
        settle(1'b1);
        rd(8'h7F, 3);
        check(rx[23:0], 24'hAB44EE);
    endtask
    task automatic t_wp();
        go(128'h06, 8);
        wp_n = 1'b0;
        repeat (5) @(negedge clk);
        check(write_latch, 1'b0);
        go(128'h06, 8);
        go(128'h0100, 16);
        check(write_latch, 1'b0);
        settle(1'b0);
        check(block_protect, 2'h1);
        wp_n = 1'b1;
    endtask
    task automatic t_frame();
        go(128'h06, 8);
        go(128'h010, 12);
        settle(1'b0);
        go(128'h0200, 16);
        settle(1'b0);
        go(128'h0100_002D, 31);
        settle(1'b0);
        check(write_latch, 1'b1);
        go(128'h04, 8);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_latch();
        t_page();
        t_prot();
        t_wp();
        t_frame();
        give_verdict();
    end
endmodule
`default_nettype wire
